// file: cmf_defines.svh
/*
  register offsets, field positions, reset values and mode codes of the compare unit.
  assumes: included by its bare name by the design module and the bench.
*/
`ifndef CMF_DEFINES_SVH
`define CMF_DEFINES_SVH

// register offsets on the plain port
`define CMF_OFF_FLAGS 4'h0
`define CMF_OFF_GCTRL 4'h1
`define CMF_OFF_ENABLES 4'h2
`define CMF_OFF_T1_HIGH 4'h3
`define CMF_OFF_T1_LOW 4'h4
`define CMF_OFF_T1_CTRL 4'h5
`define CMF_OFF_CMP_LOW 4'h6
`define CMF_OFF_CMP_HIGH 4'h7
`define CMF_OFF_CCP_CTRL 4'h8
`define CMF_OFF_T2_PERIOD 4'h9
`define CMF_OFF_T2_COUNT 4'ha
`define CMF_OFF_DIR_B 4'hb

// flag and enable bit positions
`define CMF_BIT_ADC 6
`define CMF_BIT_CCP 2
`define CMF_BIT_T2 1
`define CMF_BIT_T1 0
`define CMF_FLAG_MASK 8'h47
`define CMF_BIT_GIE 7
`define CMF_BIT_PERIPHERAL_IRQ_ENABLE 6
`define CMF_BIT_T1_ON 0

// reset values
`define CMF_RST_FLAGS 8'h00
`define CMF_RST_GCTRL 8'h00
`define CMF_RST_ENABLES 8'h00
`define CMF_RST_T1_CTRL 8'h00
`define CMF_RST_CCP_CTRL 8'h00
`define CMF_RST_T2_PERIOD 8'hff
`define CMF_RST_T2_COUNT 8'h00
`define CMF_RST_DIR_B 8'hff

// compare sub-mode codes of the mode field
`define CMF_MODE_SET 4'h8
`define CMF_MODE_CLEAR 4'h9
`define CMF_MODE_SWINT 4'ha
`define CMF_MODE_SPECIAL 4'hb
`define CMF_MODE_TOGGLE 4'h2
`define CMF_MODE_OFF 4'h0

`endif

// file: cmf_pkg.sv
/*
  types shared by the compare-match block.
  assumes: nothing beyond the defines header.
*/
package cmf_pkg;
  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cmf_bus_t;

  // events from the neighbouring timer1, capture and converter logic
  typedef struct packed {
    logic adc_done;
    logic capture;
    logic t1_tick;
  } cmf_evt_t;

  typedef enum logic [1:0] {
    CMF_IDLE,
    CMF_WAIT_TICK
  } cmf_seq_t;

  // whole module state
  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] gctrl;
    logic [7:0] enables;
    logic [15:0] t1_count;
    logic [7:0] t1_ctrl;
    logic [15:0] cmp_value;
    logic [7:0] ccp_ctrl;
    logic [7:0] t2_period;
    logic [7:0] t2_count;
    logic [7:0] dir_b;
    logic out_latch;
    logic match_d;
    logic adc_go;
    cmf_seq_t seq;
    logic [7:0] rdata;
  } cmf_state_t;
endpackage : cmf_pkg

// file: cmf_compare.sv
/*
  compare-match unit with timer1 count, timer2 period match and peripheral flag register.
  assumes: one clock, synchronous inputs, software the only bus master, the converter
  reports completion with a one-cycle pulse.
*/
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "cmf_defines.svh"

module cmf_compare (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire cmf_pkg::cmf_bus_t bus,
  output logic [7:0] rdata,
  input wire cmf_pkg::cmf_evt_t evt,
  input wire logic t2_tick,
  input wire logic capture_mode,
  output logic special_trigger,
  output logic adc_go,
  output logic ccp_pin_o,
  output logic ccp_pin_oe,
  output logic irq_req
);
  import cmf_pkg::*;

  // ==========================================================
  // state
  cmf_state_t s_reg;
  cmf_state_t s_next;
  logic [3:0] mode;
  logic compare_on;
  logic match;
  logic [16:0] t1_sum;
  logic [7:0] t2_inc;

  assign mode = s_reg.ccp_ctrl[3:0];
  assign compare_on = (mode[3:2] == 2'b10) || (mode == `CMF_MODE_TOGGLE);
  // equality seen on every count value
  assign match = compare_on && (s_reg.t1_count == s_reg.cmp_value);
  // trigger is combinational so it asserts in the match cycle itself
  assign special_trigger = match && (mode == `CMF_MODE_SPECIAL);
  assign t1_sum = {1'b0, s_reg.t1_count} + 17'h00001;
  assign t2_inc = s_reg.t2_count + 8'h01;

  // ==========================================================
  // next state
  always_comb begin
    s_next = s_reg;
    s_next.adc_go = 1'b0;
    s_next.match_d = match;
    // timer1 counting; pending special clear takes the next tick
    if (s_reg.t1_ctrl[`CMF_BIT_T1_ON] && evt.t1_tick) begin
      if (s_reg.seq == CMF_WAIT_TICK) begin
        if (match) begin
          s_next.t1_count = 16'h0000;
        end else begin
          s_next.t1_count = t1_sum[15:0];
          // compare moved off before the tick: a plain count, so a wrap still flags
          if (t1_sum[16]) begin
            s_next.flags[`CMF_BIT_T1] = 1'b1;
          end
        end
        s_next.seq = CMF_IDLE;
      end else begin
        s_next.t1_count = t1_sum[15:0];
        // a natural wrap only; the special clear path never gets here
        if (t1_sum[16]) begin
          s_next.flags[`CMF_BIT_T1] = 1'b1;
        end
      end
    end
    // rising match edge fires the mode action once per match
    if (match && !s_reg.match_d) begin
      s_next.flags[`CMF_BIT_CCP] = 1'b1;
      case (mode)
        `CMF_MODE_TOGGLE: s_next.out_latch = !s_reg.out_latch;
        `CMF_MODE_SET: s_next.out_latch = 1'b1;
        `CMF_MODE_CLEAR: s_next.out_latch = 1'b0;
        `CMF_MODE_SPECIAL: begin
          s_next.seq = CMF_WAIT_TICK;
          s_next.adc_go = 1'b1;
        end
        default: s_next.out_latch = s_reg.out_latch;
      endcase
    end
    // moving the compare value off the count before the tick cancels the clear
    if (s_reg.seq == CMF_WAIT_TICK && !match) begin
      s_next.seq = CMF_IDLE;
    end
    // timer2 period match
    if (t2_tick) begin
      if (s_reg.t2_count == s_reg.t2_period) begin
        s_next.t2_count = 8'h00;
        s_next.flags[`CMF_BIT_T2] = 1'b1;
      end else begin
        s_next.t2_count = t2_inc;
      end
    end
    // capture events count only while capture_mode is high
    if (evt.capture && capture_mode) begin
      s_next.flags[`CMF_BIT_CCP] = 1'b1;
    end
    // register writes; hardware sets below so a set wins over the clear
    if (bus.wr) begin
      case (bus.addr)
        `CMF_OFF_FLAGS: s_next.flags = bus.wdata & `CMF_FLAG_MASK;
        `CMF_OFF_GCTRL: s_next.gctrl = bus.wdata;
        `CMF_OFF_ENABLES: s_next.enables = bus.wdata & `CMF_FLAG_MASK;
        `CMF_OFF_T1_HIGH: s_next.t1_count[15:8] = bus.wdata;
        `CMF_OFF_T1_LOW: s_next.t1_count[7:0] = bus.wdata;
        `CMF_OFF_T1_CTRL: s_next.t1_ctrl = bus.wdata & 8'h3f;
        `CMF_OFF_CMP_LOW: s_next.cmp_value[7:0] = bus.wdata;
        `CMF_OFF_CMP_HIGH: s_next.cmp_value[15:8] = bus.wdata;
        `CMF_OFF_CCP_CTRL: begin
          s_next.ccp_ctrl = bus.wdata;
          if (bus.wdata == 8'h00) begin
            s_next.out_latch = 1'b0;
            s_next.seq = CMF_IDLE;
          end
        end
        `CMF_OFF_T2_PERIOD: s_next.t2_period = bus.wdata;
        `CMF_OFF_T2_COUNT: s_next.t2_count = bus.wdata;
        `CMF_OFF_DIR_B: s_next.dir_b = bus.wdata;
        default: s_next.gctrl = s_next.gctrl;
      endcase
    end
    // re-apply hardware sets of this cycle over a software write
    if (bus.wr && bus.addr == `CMF_OFF_FLAGS) begin
      if (match && !s_reg.match_d) begin
        s_next.flags[`CMF_BIT_CCP] = 1'b1;
      end
      if (evt.capture && capture_mode) begin
        s_next.flags[`CMF_BIT_CCP] = 1'b1;
      end
      if (t2_tick && s_reg.t2_count == s_reg.t2_period) begin
        s_next.flags[`CMF_BIT_T2] = 1'b1;
      end
      if (s_reg.t1_ctrl[`CMF_BIT_T1_ON] && evt.t1_tick
          && (s_reg.seq == CMF_IDLE || !match) && t1_sum[16]) begin
        s_next.flags[`CMF_BIT_T1] = 1'b1;
      end
    end
    if (evt.adc_done) begin
      s_next.flags[`CMF_BIT_ADC] = 1'b1;
    end
    // read data in the cycle after the strobe
    s_next.rdata = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        `CMF_OFF_FLAGS: s_next.rdata = s_reg.flags & `CMF_FLAG_MASK;
        `CMF_OFF_GCTRL: s_next.rdata = s_reg.gctrl;
        `CMF_OFF_ENABLES: s_next.rdata = s_reg.enables;
        `CMF_OFF_T1_HIGH: s_next.rdata = s_reg.t1_count[15:8];
        `CMF_OFF_T1_LOW: s_next.rdata = s_reg.t1_count[7:0];
        `CMF_OFF_T1_CTRL: s_next.rdata = s_reg.t1_ctrl;
        `CMF_OFF_CMP_LOW: s_next.rdata = s_reg.cmp_value[7:0];
        `CMF_OFF_CMP_HIGH: s_next.rdata = s_reg.cmp_value[15:8];
        `CMF_OFF_CCP_CTRL: s_next.rdata = s_reg.ccp_ctrl;
        `CMF_OFF_T2_PERIOD: s_next.rdata = s_reg.t2_period;
        `CMF_OFF_T2_COUNT: s_next.rdata = s_reg.t2_count;
        `CMF_OFF_DIR_B: s_next.rdata = s_reg.dir_b;
        default: s_next.rdata = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // registers; clock enable freezes everything
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.flags <= `CMF_RST_FLAGS;
      s_reg.gctrl <= `CMF_RST_GCTRL;
      s_reg.enables <= `CMF_RST_ENABLES;
      s_reg.t1_ctrl <= `CMF_RST_T1_CTRL;
      s_reg.ccp_ctrl <= `CMF_RST_CCP_CTRL;
      s_reg.t2_period <= `CMF_RST_T2_PERIOD;
      s_reg.t2_count <= `CMF_RST_T2_COUNT;
      s_reg.dir_b <= `CMF_RST_DIR_B;
      s_reg.seq <= CMF_IDLE;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // outputs
  assign rdata = s_reg.rdata;
  assign adc_go = s_reg.adc_go;
  assign ccp_pin_o = s_reg.out_latch;
  // pin driven only in pin-action modes and with direction bit cleared
  assign ccp_pin_oe = !s_reg.dir_b[0] && (mode == `CMF_MODE_SET || mode == `CMF_MODE_CLEAR
                      || mode == `CMF_MODE_TOGGLE);
  assign irq_req = s_reg.gctrl[`CMF_BIT_GIE] && s_reg.gctrl[`CMF_BIT_PERIPHERAL_IRQ_ENABLE]
                   && |(s_reg.flags & s_reg.enables & `CMF_FLAG_MASK);

  // ==========================================================
  // checks
  sequence seq_special_match;
    special_trigger && !s_reg.match_d && clk_en;
  endsequence

  chk_flag_ccp_set: assert property (@(posedge clk) disable iff (!rst_n)
    (match && !s_reg.match_d && clk_en) |=> s_reg.flags[`CMF_BIT_CCP])
    else $error("ccp flag not set on match");
  chk_adc_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (evt.adc_done && clk_en) |=> s_reg.flags[`CMF_BIT_ADC])
    else $error("adc flag not set");
  chk_unimpl_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.flags & ~`CMF_FLAG_MASK) == 8'h00)
    else $error("unimplemented flag bit set");
  chk_go_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    seq_special_match |=> adc_go ##1 !adc_go)
    else $error("go pulse wrong");
  chk_special_wait: assert property (@(posedge clk) disable iff (!rst_n)
    seq_special_match |=> s_reg.seq == CMF_WAIT_TICK)
    else $error("special clear not armed");
  chk_t1_cleared: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.seq == CMF_WAIT_TICK && match && evt.t1_tick && s_reg.t1_ctrl[0] && clk_en
     && !bus.wr) |=> (s_reg.t1_count == 16'h0000 && !$rose(s_reg.flags[`CMF_BIT_T1])))
    else $error("timer1 not cleared cleanly");
  chk_zero_ctrl: assert property (@(posedge clk) disable iff (!rst_n)
    (bus.wr && bus.addr == `CMF_OFF_CCP_CTRL && bus.wdata == 8'h00 && clk_en)
    |=> !ccp_pin_o)
    else $error("latch not forced low");
  chk_irq_gate: assert property (@(posedge clk) disable iff (!rst_n)
    irq_req |-> s_reg.gctrl[`CMF_BIT_GIE])
    else $error("request without global enable");
  chk_special_pin: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == `CMF_MODE_SPECIAL || mode == `CMF_MODE_SWINT) |-> !ccp_pin_oe)
    else $error("pin taken in no-pin mode");

  // ==========================================================
  // event checks; the recurring steps are named sequences so the properties using them read as
  // the hardware event followed by its effect one enabled cycle later
  sequence seq_t1_step;
    s_reg.t1_ctrl[`CMF_BIT_T1_ON] && evt.t1_tick && clk_en;
  endsequence

  sequence seq_match_rise;
    match && !s_reg.match_d && clk_en;
  endsequence

  sequence seq_t2_hit;
    t2_tick && (s_reg.t2_count == s_reg.t2_period) && clk_en;
  endsequence

  sequence seq_flags_write;
    bus.wr && (bus.addr == `CMF_OFF_FLAGS) && clk_en;
  endsequence

  sequence seq_capture;
    evt.capture && capture_mode && clk_en;
  endsequence

  // a control write in the same cycle may zero the latch, so it is excluded
  sequence seq_ctrl_quiet;
    !(bus.wr && bus.addr == `CMF_OFF_CCP_CTRL);
  endsequence

  // timer2 period match raises its flag and restarts the count
  chk_t2_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
    seq_t2_hit |=> s_reg.flags[`CMF_BIT_T2])
    else $error("t2 flag not set on period match");
  chk_t2_restart: assert property (@(posedge clk) disable iff (!rst_n)
    seq_t2_hit ##0 !(bus.wr && bus.addr == `CMF_OFF_T2_COUNT)
    |=> s_reg.t2_count == 8'h00)
    else $error("t2 count not restarted");

  // capture events land in the shared ccp flag
  chk_capture_flag: assert property (@(posedge clk) disable iff (!rst_n)
    seq_capture |=> s_reg.flags[`CMF_BIT_CCP])
    else $error("ccp flag not set on capture");

  // a natural wrap flags; only the armed special clear is exempt
  chk_t1_wrap_flag: assert property (@(posedge clk) disable iff (!rst_n)
    seq_t1_step ##0 (s_reg.t1_count == 16'hffff)
    ##0 !(s_reg.seq == CMF_WAIT_TICK && match)
    |=> s_reg.flags[`CMF_BIT_T1])
    else $error("t1 overflow flag not set on wrap");

  // flags are sticky: only a software write to the flag register drops them
  chk_t1_flag_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.flags[`CMF_BIT_T1] && !(bus.wr && bus.addr == `CMF_OFF_FLAGS))
    |=> s_reg.flags[`CMF_BIT_T1])
    else $error("t1 overflow flag dropped");
  chk_ccp_flag_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.flags[`CMF_BIT_CCP] && !(bus.wr && bus.addr == `CMF_OFF_FLAGS))
    |=> s_reg.flags[`CMF_BIT_CCP])
    else $error("ccp flag dropped");
  chk_t2_flag_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.flags[`CMF_BIT_T2] && !(bus.wr && bus.addr == `CMF_OFF_FLAGS))
    |=> s_reg.flags[`CMF_BIT_T2])
    else $error("t2 flag dropped");

  // no conversion done and no write: the converter flag stays clear
  chk_adc_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    (!s_reg.flags[`CMF_BIT_ADC] && !evt.adc_done
     && !(bus.wr && bus.addr == `CMF_OFF_FLAGS))
    |=> !s_reg.flags[`CMF_BIT_ADC])
    else $error("adc flag set without completion");

  // writing zero with no event pending empties the flag register
  chk_flag_clear: assert property (@(posedge clk) disable iff (!rst_n)
    seq_flags_write ##0 (bus.wdata == 8'h00 && !evt.adc_done && !evt.capture
    && !evt.t1_tick && !t2_tick && !match)
    |=> s_reg.flags == 8'h00)
    else $error("flag write did not clear");

  // reads show the flag register with its hole positions at zero
  chk_flag_read: assert property (@(posedge clk) disable iff (!rst_n)
    (bus.rd && bus.addr == `CMF_OFF_FLAGS && clk_en)
    |=> rdata == ($past(s_reg.flags) & `CMF_FLAG_MASK))
    else $error("flag read wrong");

  // read data stands one cycle only, zero otherwise
  chk_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
    (!bus.rd && clk_en) |=> rdata == 8'h00)
    else $error("read data outside its cycle");

  // the trigger follows the match with no register in between
  chk_trigger_now: assert property (@(posedge clk) disable iff (!rst_n)
    (match && mode == `CMF_MODE_SPECIAL) |-> special_trigger)
    else $error("special trigger late");

  // losing the match before the tick drops the pending clear
  chk_clear_cancel: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.seq == CMF_WAIT_TICK && !match && clk_en) |=> s_reg.seq == CMF_IDLE)
    else $error("pending clear survived lost match");

  // pin actions of the sub-modes on a rising match
  chk_set_mode: assert property (@(posedge clk) disable iff (!rst_n)
    seq_match_rise ##0 (mode == `CMF_MODE_SET) ##0 seq_ctrl_quiet
    |=> ccp_pin_o)
    else $error("set mode left latch low");
  chk_clear_mode: assert property (@(posedge clk) disable iff (!rst_n)
    seq_match_rise ##0 (mode == `CMF_MODE_CLEAR) ##0 seq_ctrl_quiet
    |=> !ccp_pin_o)
    else $error("clear mode left latch high");
  chk_toggle_mode: assert property (@(posedge clk) disable iff (!rst_n)
    seq_match_rise ##0 (mode == `CMF_MODE_TOGGLE) ##0 seq_ctrl_quiet
    |=> ccp_pin_o != $past(ccp_pin_o))
    else $error("toggle mode kept latch");
  chk_swint_keep: assert property (@(posedge clk) disable iff (!rst_n)
    seq_match_rise ##0 (mode == `CMF_MODE_SWINT) ##0 seq_ctrl_quiet
    |=> ccp_pin_o == $past(ccp_pin_o))
    else $error("flag-only mode moved latch");

  // request only with every gate open, and always then
  chk_irq_need: assert property (@(posedge clk) disable iff (!rst_n)
    irq_req |-> (s_reg.gctrl[`CMF_BIT_PERIPHERAL_IRQ_ENABLE] && |(s_reg.flags & s_reg.enables)))
    else $error("request without pending enabled flag");
  chk_irq_raise: assert property (@(posedge clk) disable iff (!rst_n)
    (s_reg.gctrl[`CMF_BIT_GIE] && s_reg.gctrl[`CMF_BIT_PERIPHERAL_IRQ_ENABLE]
     && |(s_reg.flags & s_reg.enables & `CMF_FLAG_MASK)) |-> irq_req)
    else $error("request missing");

  // drive only in the three pin-action modes
  chk_pin_modes: assert property (@(posedge clk) disable iff (!rst_n)
    ccp_pin_oe |-> (mode == `CMF_MODE_SET || mode == `CMF_MODE_CLEAR
    || mode == `CMF_MODE_TOGGLE))
    else $error("pin driven in wrong mode");

  // clock enable low freezes every bit of state
  chk_freeze: assert property (@(posedge clk) disable iff (!rst_n)
    !clk_en |=> $stable(s_reg))
    else $error("state moved while frozen");
endmodule : cmf_compare
`default_nettype wire

// file: tb_top.sv
/*
  self-checking bench for the compare-match block: register port tasks, directed tests.
  assumes: cmf_pkg and cmf_defines.svh compiled alongside, one 100 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cmf_defines.svh"

module tb_top;
  import cmf_pkg::*;
  // ==========================================
  // stimulus and observation signals
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  cmf_bus_t bus = '0;
  cmf_evt_t evt = '0;
  logic t2_tick = 1'b0;
  logic capture_mode = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] rdata;
  logic special_trigger;
  logic adc_go;
  logic ccp_pin_o;
  logic ccp_pin_oe;
  logic irq_req;
  int n_fail = 0;
  int n_tests = 0;
  int cycles = 0;
  int hits;
  // pulse masks over {t2_tick, adc_done, capture, t1_tick}
  localparam logic [3:0] P_T1 = 4'h1;
  localparam logic [3:0] P_CAP = 4'h2;
  localparam logic [3:0] P_ADC = 4'h4;
  localparam logic [3:0] P_T2 = 4'h8;
  // reset table, unmapped offset f last; timer1 and compare bytes reset to zero but are not read here
  logic [3:0] ra [9] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h8, 4'h9, 4'ha, 4'hb, 4'hf};
  logic [7:0] re [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00};
  // compare sub-modes with expected latch and drive; toggle first so it starts from low
  logic [3:0] cm [4] = '{4'h2, 4'h9, 4'h8, 4'ha};
  logic cp [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
  logic co [4] = '{1'b1, 1'b1, 1'b1, 1'b0};

  always #5 clk = ~clk;

  cmf_compare i_dut (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .bus(bus),
    .rdata(rdata),
    .evt(evt),
    .t2_tick(t2_tick),
    .capture_mode(capture_mode),
    .special_trigger(special_trigger),
    .adc_go(adc_go),
    .ccp_pin_o(ccp_pin_o),
    .ccp_pin_oe(ccp_pin_oe),
    .irq_req(irq_req)
  );

  // ==========================================
  // shared tasks
  task check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask : rd_chk

  // one-cycle event pulses with a gap, as the neighbouring logic makes them
  task pulse(input logic [3:0] m, input int n);
    repeat (n) begin
      @(posedge clk);
      {t2_tick, evt} <= m;
      @(posedge clk);
      {t2_tick, evt} <= 4'h0;
    end
  endtask : pulse

  task report_and_stop;
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  // ==========================================
  // hang guard, far above the roughly 200 cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_fail++;
      report_and_stop();
    end
  end

  // ==========================================
  // directed tests
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 9; i++) rd_chk(ra[i], re[i]);
    wr(`CMF_OFF_FLAGS, 8'hff);
    rd_chk(`CMF_OFF_FLAGS, 8'h47);
    wr(`CMF_OFF_FLAGS, 8'h00);
    rd_chk(`CMF_OFF_FLAGS, 8'h00);
    // converter done with every enable off, then unmask step by step
    pulse(P_ADC, 1);
    rd_chk(`CMF_OFF_FLAGS, 8'h40);
    check({7'h0, irq_req}, 8'h00);
    wr(`CMF_OFF_ENABLES, 8'h40);
    wr(`CMF_OFF_GCTRL, 8'h40);
    #1 check({7'h0, irq_req}, 8'h00);
    wr(`CMF_OFF_GCTRL, 8'hc0);
    #1 check({7'h0, irq_req}, 8'h01);
    wr(`CMF_OFF_FLAGS, 8'h00);
    #1 check({7'h0, irq_req}, 8'h00);
    wr(`CMF_OFF_GCTRL, 8'h00);
    // capture event
    @(posedge clk);
    capture_mode <= 1'b1;
    pulse(P_CAP, 1);
    rd_chk(`CMF_OFF_FLAGS, 8'h04);
    @(posedge clk);
    capture_mode <= 1'b0;
    wr(`CMF_OFF_FLAGS, 8'h00);
    // timer2 period match, flag held across later reads
    wr(`CMF_OFF_T2_PERIOD, 8'h02);
    pulse(P_T2, 4);
    rd_chk(`CMF_OFF_FLAGS, 8'h02);
    rd_chk(`CMF_OFF_FLAGS, 8'h02);
    wr(`CMF_OFF_FLAGS, 8'h00);
    // compare sub-modes, match reached at 0010 after two ticks
    wr(`CMF_OFF_DIR_B, 8'hfe);
    wr(`CMF_OFF_CMP_HIGH, 8'h00);
    wr(`CMF_OFF_CMP_LOW, 8'h10);
    wr(`CMF_OFF_T1_CTRL, 8'h01);
    for (int i = 0; i < 4; i++) begin
      wr(`CMF_OFF_T1_HIGH, 8'h00);
      wr(`CMF_OFF_T1_LOW, 8'h0e);
      wr(`CMF_OFF_CCP_CTRL, {4'h0, cm[i]});
      pulse(P_T1, 1);
      rd_chk(`CMF_OFF_FLAGS, 8'h00);
      pulse(P_T1, 1);
      repeat (2) @(posedge clk);
      #1 check({6'h0, ccp_pin_oe, ccp_pin_o}, {6'h0, co[i], cp[i]});
      rd_chk(`CMF_OFF_FLAGS, 8'h04);
      wr(`CMF_OFF_FLAGS, 8'h00);
    end
    // all-zero control drops the latch left high by the set mode
    wr(`CMF_OFF_CCP_CTRL, 8'h00);
    #1 check({6'h0, ccp_pin_oe, ccp_pin_o}, 8'h00);
    // special trigger: immediate output, one go pulse, clear on next tick
    wr(`CMF_OFF_T1_LOW, 8'h0f);
    wr(`CMF_OFF_CCP_CTRL, 8'h0b);
    pulse(P_T1, 1);
    #1 check({7'h0, special_trigger}, 8'h01);
    hits = 0;
    repeat (4) begin
      @(posedge clk);
      #1 hits += adc_go;
    end
    check(hits[7:0], 8'h01);
    check({7'h0, ccp_pin_oe}, 8'h00);
    rd_chk(`CMF_OFF_T1_LOW, 8'h10);
    pulse(P_T1, 1);
    rd_chk(`CMF_OFF_T1_LOW, 8'h00);
    rd_chk(`CMF_OFF_T1_HIGH, 8'h00);
    rd_chk(`CMF_OFF_FLAGS, 8'h04);
    wr(`CMF_OFF_CCP_CTRL, 8'h00);
    wr(`CMF_OFF_FLAGS, 8'h00);
    // timer1 wrap from fffe
    wr(`CMF_OFF_T1_HIGH, 8'hff);
    wr(`CMF_OFF_T1_LOW, 8'hfe);
    pulse(P_T1, 2);
    rd_chk(`CMF_OFF_FLAGS, 8'h01);
    rd_chk(`CMF_OFF_FLAGS, 8'h01);
    // ticks while frozen must not move timer1
    @(posedge clk);
    clk_en <= 1'b0;
    pulse(P_T1, 2);
    @(posedge clk);
    clk_en <= 1'b1;
    rd_chk(`CMF_OFF_T1_LOW, 8'h00);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
